/* File: logic/tsc_pkg.sv */
/*
 * constants shared by the splitter strap and port control logic:
 * register indices, field positions, reset values and strap encodings.
 * assumes 8-bit registers held in the low byte of 32-bit wishbone words.
 */
package tsc_pkg;

   // register indices, byte address is four times the index
   localparam logic [2:0] IDX_CFG = 3'h0;
   localparam logic [2:0] IDX_RX = 3'h1;
   localparam logic [2:0] IDX_RSV2 = 3'h2;
   localparam logic [2:0] IDX_TX1 = 3'h3;
   localparam logic [2:0] IDX_TX2 = 3'h4;
   localparam logic [2:0] IDX_RSV5 = 3'h5;
   localparam logic [2:0] IDX_RSV6 = 3'h6;
   localparam logic [2:0] IDX_STATUS = 3'h7;

   // reset values
   localparam logic [7:0] RST_CFG = 8'hff;
   localparam logic [7:0] RST_RX = 8'h00;
   localparam logic [7:0] RST_RSV2 = 8'h00;
   localparam logic [7:0] RST_TX = 8'h00;
   localparam logic [7:0] RST_RSV5 = 8'h00;
   localparam logic [7:0] RST_RSV6 = 8'h0f;

   // config register fields
   localparam int CFG_NORMAL_BIT = 7;
   localparam int CFG_P1_EN_BIT = 5;
   localparam int CFG_P2_EN_BIT = 4;

   // receiver setting fields
   localparam int RX_PD_OFF_BIT = 7;
   localparam int RX_VBIAS_VDD_BIT = 6;
   localparam int RX_VBIAS_EN_BIT = 5;
   localparam int RX_EQ_LSB = 2;
   localparam int RX_SQ_OFF_BIT = 1;

   // port output setting fields
   localparam int TX_TERM_BIT = 7;
   localparam int TX_EMPH_LSB = 4;
   localparam int TX_SWING_LSB = 2;
   localparam int TX_SLEW_LSB = 0;

   // status register fields
   localparam int ST_SERIAL_BIT = 0;
   localparam int ST_SQUELCH_BIT = 1;
   localparam int ST_P1_BIT = 2;
   localparam int ST_P2_BIT = 3;
   localparam int ST_EQ_LSB = 4;

   // fixed upper bits of the serial bus device address
   localparam logic [2:0] BUS_ADDR_FIXED = 3'h5;

   // equalization steps, 2.5 dB apart from 2.5 dB upward
   localparam logic [2:0] EQ_STEP_DEFAULT = 3'h4;

   // three-level strap reading
   typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} tsc_lvl_t;

endpackage

/* File: logic/tsc_port_cfg.sv */
/*
 * per-port output setting selector: picks swing, pre-emphasis and source
 * termination from straps with slew fixed at zero, or all four from the port's setting register.
 * combinational; the caller registers the results.
 */
`timescale 1ns/1ps
module tsc_port_cfg
   import tsc_pkg::*;
(
   input wire logic pin_mode,
   input wire logic [1:0] swing_strap,
   input wire logic [1:0] emph_strap,
   input wire logic term_pin,
   input wire logic [7:0] tx_reg,
   output logic [1:0] swing,
   output logic [2:0] emph,
   output logic [1:0] slew,
   output logic src_term
);

   // strap values in pin mode with slew fixed at zero, register fields otherwise
   always_comb begin
      if (pin_mode) begin
         swing = swing_strap;
         emph = {1'b0, emph_strap};
         slew = 2'h0;
         src_term = term_pin;
      end else begin
         swing = tx_reg[TX_SWING_LSB +: 2];
         emph = tx_reg[TX_EMPH_LSB +: 3];
         slew = tx_reg[TX_SLEW_LSB +: 2];
         src_term = tx_reg[TX_TERM_BIT];
      end
   end

endmodule // tsc_port_cfg

/* File: logic/tsc_strap_ctrl.sv */
/*
 * strap decode, control mode choice and port control of a one-in,
 * two-out video splitter, with its setting registers on wishbone.
 * assumes all strap and status pins are synchronous to CLOCK and that
 * floating detection of the equalizer straps is done by the pad.
 */
// How it works
// - mode strap high picks serial register control, low picks pin straps.
// - in pin mode two swing straps pick nominal, -10, +10 or +20 percent.
// - in pin mode two emphasis straps pick 0, 1.5, 2.5 or 3.5 dB.
// - output enable low disables ports, input termination, receiver and drivers.
// - broadcast pin high drives both ports, low drives only the chosen one.
// - port choice high enables port 2, low enables port 1.
// - port status output follows the port 1 enable bit of the config register.
// - termination pin high turns source termination on, low gives open drain.
// - swapped input clock polarity swaps output clock polarity on both ports.
// - tied input termination turns the input pull-down off; registers control both.
// - squelch turns outputs off while no valid input clock is seen.
// - serial mode takes port choice, emphasis, swing and slew from registers.
// - serial mode bus address is 101 then the four shared strap pins.
// - clock below threshold disables ports; above it normal swing returns.
// - config holds normal mode bit 7, port 1 bit 5, port 2 bit 4, all set.
`timescale 1ns/1ps
module tsc_strap_ctrl
   import tsc_pkg::*;
(
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic CONTROL_MODE_STRAP,
   input wire logic EQUALIZER_STRAP_HIGH,
   input wire logic EQUALIZER_STRAP_HIGH_FLOAT,
   input wire logic EQUALIZER_STRAP_LOW,
   input wire logic EQUALIZER_STRAP_LOW_FLOAT,
   input wire logic SWING_STRAP_LOW,
   input wire logic SWING_STRAP_HIGH,
   input wire logic EMPHASIS_STRAP_LOW,
   input wire logic EMPHASIS_STRAP_HIGH,
   input wire logic OUTPUT_ENABLE_PIN,
   input wire logic BROADCAST_SELECT_PIN,
   input wire logic PORT_CHOICE_PIN,
   input wire logic TERM_SELECT_PIN,
   input wire logic CLK_POLARITY_SWAPPED,
   input wire logic CLK_DETECT,
   output logic SERIAL_MODE,
   output logic [6:0] CFG_BUS_ADDR,
   output logic [2:0] EQ_STEP,
   output logic PORT1_ACTIVE,
   output logic PORT2_ACTIVE,
   output logic [1:0] PORT1_SWING,
   output logic [1:0] PORT2_SWING,
   output logic [2:0] PORT1_EMPH,
   output logic [2:0] PORT2_EMPH,
   output logic [1:0] PORT1_SLEW,
   output logic [1:0] PORT2_SLEW,
   output logic PORT1_SRC_TERM,
   output logic PORT2_SRC_TERM,
   output logic PORT1_CLK_SWAP,
   output logic PORT2_CLK_SWAP,
   output logic RX_POWER,
   output logic DRV_POWER,
   output logic INPUT_TERMINATION_ON,
   output logic INPUT_TERMINATION_TIED,
   output logic INPUT_TERMINATION_VDD,
   output logic INPUT_PULLDOWN_ON,
   output logic SQUELCH,
   output logic PORT_STATUS
);

   // setting registers
   logic [7:0] cfg_r;
   logic [7:0] rx_r;
   logic [7:0] rsv2_r;
   logic [7:0] tx1_r;
   logic [7:0] tx2_r;
   logic [7:0] rsv5_r;
   logic [7:0] rsv6_r;

   // bus slave state
   logic ack_r;
   logic [31:0] dat_r;
   logic req;
   logic mapped;
   logic [2:0] idx;
   logic wr_en;
   logic [7:0] rd_byte;

   // decoded control
   logic pin_mode;
   tsc_lvl_t eq_hi_lvl;
   tsc_lvl_t eq_lo_lvl;
   logic [2:0] eq_nxt;
   logic squelch_nxt;
   logic powered;
   logic p1_want;
   logic p2_want;
   logic p1_nxt;
   logic p2_nxt;
   logic term_tied_nxt;
   logic pd_nxt;
   logic [7:0] status_byte;

   // per-port selector results
   logic [1:0] p1_swing;
   logic [1:0] p2_swing;
   logic [2:0] p1_emph;
   logic [2:0] p2_emph;
   logic [1:0] p1_slew;
   logic [1:0] p2_slew;
   logic p1_term;
   logic p2_term;

   // registered copies of outputs
   logic serial_r;
   logic [6:0] bus_addr_r;
   logic [2:0] eq_r;
   logic p1_act_r;
   logic p2_act_r;
   logic [1:0] p1_swing_r;
   logic [1:0] p2_swing_r;
   logic [2:0] p1_emph_r;
   logic [2:0] p2_emph_r;
   logic [1:0] p1_slew_r;
   logic [1:0] p2_slew_r;
   logic p1_term_r;
   logic p2_term_r;
   logic clk_swap_r;
   logic rx_pwr_r;
   logic drv_pwr_r;
   logic term_on_r;
   logic term_tied_r;
   logic term_vdd_r;
   logic pd_on_r;
   logic squelch_r;
   logic port_status_r;

   // address decode, one word per register
   assign req = WB_CYC_I & WB_STB_I;
   assign mapped = (WB_ADR_I[7:5] == 3'h0) && (WB_ADR_I[1:0] == 2'h0);
   assign idx = WB_ADR_I[4:2];
   assign wr_en = req & ack_r & WB_WE_I & WB_SEL_I[0] & mapped;

   // mode strap, unconnected reads high by pull-up
   assign pin_mode = ~CONTROL_MODE_STRAP;

   // three-level strap readings, floating wins over level
   assign eq_hi_lvl = EQUALIZER_STRAP_HIGH_FLOAT ? LVL_MID : (EQUALIZER_STRAP_HIGH ? LVL_HIGH : LVL_LOW);
   assign eq_lo_lvl = EQUALIZER_STRAP_LOW_FLOAT ? LVL_MID : (EQUALIZER_STRAP_LOW ? LVL_HIGH : LVL_LOW);

   // equalizer step from straps or register
   always_comb begin
      eq_nxt = EQ_STEP_DEFAULT;
      if (!pin_mode) begin
         eq_nxt = rx_r[RX_EQ_LSB +: 3];
      end else begin
         unique case ({eq_hi_lvl, eq_lo_lvl})
            {LVL_LOW, LVL_MID}: eq_nxt = 3'h0;
            {LVL_LOW, LVL_LOW}: eq_nxt = 3'h1;
            {LVL_MID, LVL_LOW}: eq_nxt = 3'h2;
            {LVL_LOW, LVL_HIGH}: eq_nxt = 3'h3;
            {LVL_MID, LVL_MID}: eq_nxt = 3'h4;
            {LVL_HIGH, LVL_LOW}: eq_nxt = 3'h5;
            {LVL_HIGH, LVL_MID}: eq_nxt = 3'h6;
            {LVL_HIGH, LVL_HIGH}: eq_nxt = 3'h7;
            default: eq_nxt = EQ_STEP_DEFAULT;
         endcase
      end
   end

   // squelch from the clock detector unless switched off by register
   assign squelch_nxt = OUTPUT_ENABLE_PIN & ~CLK_DETECT & ~(~pin_mode & rx_r[RX_SQ_OFF_BIT]);

   // receiver and drivers powered while enabled and not in standby
   assign powered = OUTPUT_ENABLE_PIN & (pin_mode | cfg_r[CFG_NORMAL_BIT]);

   // port choice: broadcast or single port, register bits in serial mode
   always_comb begin
      if (pin_mode) begin
         p1_want = BROADCAST_SELECT_PIN | ~PORT_CHOICE_PIN;
         p2_want = BROADCAST_SELECT_PIN | PORT_CHOICE_PIN;
      end else begin
         p1_want = cfg_r[CFG_P1_EN_BIT];
         p2_want = cfg_r[CFG_P2_EN_BIT];
      end
   end

   // a port drives only while powered and out of squelch
   assign p1_nxt = p1_want & powered & ~squelch_nxt;
   assign p2_nxt = p2_want & powered & ~squelch_nxt;

   // input termination tie and high-value pull-down
   assign term_tied_nxt = OUTPUT_ENABLE_PIN & ~pin_mode & rx_r[RX_VBIAS_EN_BIT];
   assign pd_nxt = OUTPUT_ENABLE_PIN & ~term_tied_nxt & ~(~pin_mode & rx_r[RX_PD_OFF_BIT]);

   // port 1 output settings
   tsc_port_cfg u_port1 (
      .pin_mode(pin_mode),
      .swing_strap({SWING_STRAP_HIGH, SWING_STRAP_LOW}),
      .emph_strap({EMPHASIS_STRAP_HIGH, EMPHASIS_STRAP_LOW}),
      .term_pin(TERM_SELECT_PIN),
      .tx_reg(tx1_r),
      .swing(p1_swing),
      .emph(p1_emph),
      .slew(p1_slew),
      .src_term(p1_term)
   );

   // port 2 output settings
   tsc_port_cfg u_port2 (
      .pin_mode(pin_mode),
      .swing_strap({SWING_STRAP_HIGH, SWING_STRAP_LOW}),
      .emph_strap({EMPHASIS_STRAP_HIGH, EMPHASIS_STRAP_LOW}),
      .term_pin(TERM_SELECT_PIN),
      .tx_reg(tx2_r),
      .swing(p2_swing),
      .emph(p2_emph),
      .slew(p2_slew),
      .src_term(p2_term)
   );

   // live state seen by software
   always_comb begin
      status_byte = 8'h00;
      status_byte[ST_SERIAL_BIT] = serial_r;
      status_byte[ST_SQUELCH_BIT] = squelch_r;
      status_byte[ST_P1_BIT] = p1_act_r;
      status_byte[ST_P2_BIT] = p2_act_r;
      status_byte[ST_EQ_LSB +: 3] = eq_r;
   end

   // read mux, unmapped addresses read zero
   always_comb begin
      rd_byte = 8'h00;
      if (mapped) begin
         unique case (idx)
            IDX_CFG: rd_byte = cfg_r;
            IDX_RX: rd_byte = rx_r;
            IDX_RSV2: rd_byte = rsv2_r;
            IDX_TX1: rd_byte = tx1_r;
            IDX_TX2: rd_byte = tx2_r;
            IDX_RSV5: rd_byte = rsv5_r;
            IDX_RSV6: rd_byte = rsv6_r;
            IDX_STATUS: rd_byte = status_byte;
         endcase
      end
   end

   // bus handshake: ack one cycle after the request, dropped after one
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         ack_r <= 1'b0;
         dat_r <= 32'h00000000;
      end else begin
         ack_r <= req & ~ack_r;
         if (req & ~ack_r) begin
            dat_r <= {24'h000000, rd_byte};
         end
      end
   end

   // register writes at the edge where ack is sampled
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         cfg_r <= RST_CFG;
         rx_r <= RST_RX;
         rsv2_r <= RST_RSV2;
         tx1_r <= RST_TX;
         tx2_r <= RST_TX;
         rsv5_r <= RST_RSV5;
         rsv6_r <= RST_RSV6;
      end else if (wr_en) begin
         unique case (idx)
            IDX_CFG: cfg_r <= WB_DAT_I[7:0];
            IDX_RX: rx_r <= WB_DAT_I[7:0];
            IDX_RSV2: rsv2_r <= WB_DAT_I[7:0];
            IDX_TX1: tx1_r <= WB_DAT_I[7:0];
            IDX_TX2: tx2_r <= WB_DAT_I[7:0];
            IDX_RSV5: rsv5_r <= WB_DAT_I[7:0];
            IDX_RSV6: rsv6_r <= WB_DAT_I[7:0];
            IDX_STATUS: ;
         endcase
      end
   end

   // mode, address and equalizer outputs
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         serial_r <= 1'b0;
         bus_addr_r <= 7'h00;
         eq_r <= 3'h0;
      end else begin
         serial_r <= ~pin_mode;
         bus_addr_r <= {BUS_ADDR_FIXED, EMPHASIS_STRAP_HIGH, EMPHASIS_STRAP_LOW,
                        SWING_STRAP_HIGH, SWING_STRAP_LOW};
         eq_r <= eq_nxt;
      end
   end

   // port enables, squelch and status pin
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         p1_act_r <= 1'b0;
         p2_act_r <= 1'b0;
         squelch_r <= 1'b0;
         port_status_r <= 1'b0;
      end else begin
         p1_act_r <= p1_nxt;
         p2_act_r <= p2_nxt;
         squelch_r <= squelch_nxt;
         port_status_r <= cfg_r[CFG_P1_EN_BIT];
      end
   end

   // per-port drive settings and clock polarity
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         p1_swing_r <= 2'h0;
         p2_swing_r <= 2'h0;
         p1_emph_r <= 3'h0;
         p2_emph_r <= 3'h0;
         p1_slew_r <= 2'h0;
         p2_slew_r <= 2'h0;
         p1_term_r <= 1'b0;
         p2_term_r <= 1'b0;
         clk_swap_r <= 1'b0;
      end else begin
         p1_swing_r <= p1_swing;
         p2_swing_r <= p2_swing;
         p1_emph_r <= p1_emph;
         p2_emph_r <= p2_emph;
         p1_slew_r <= p1_slew;
         p2_slew_r <= p2_slew;
         p1_term_r <= p1_term;
         p2_term_r <= p2_term;
         clk_swap_r <= CLK_POLARITY_SWAPPED;
      end
   end

   // power and input termination
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         rx_pwr_r <= 1'b0;
         drv_pwr_r <= 1'b0;
         term_on_r <= 1'b0;
         term_tied_r <= 1'b0;
         term_vdd_r <= 1'b0;
         pd_on_r <= 1'b0;
      end else begin
         rx_pwr_r <= powered;
         drv_pwr_r <= powered;
         term_on_r <= OUTPUT_ENABLE_PIN;
         term_tied_r <= term_tied_nxt;
         term_vdd_r <= term_tied_nxt & rx_r[RX_VBIAS_VDD_BIT];
         pd_on_r <= pd_nxt;
      end
   end

   // outputs straight from flops
   assign WB_ACK_O = ack_r;
   assign WB_DAT_O = dat_r;
   assign SERIAL_MODE = serial_r;
   assign CFG_BUS_ADDR = bus_addr_r;
   assign EQ_STEP = eq_r;
   assign PORT1_ACTIVE = p1_act_r;
   assign PORT2_ACTIVE = p2_act_r;
   assign PORT1_SWING = p1_swing_r;
   assign PORT2_SWING = p2_swing_r;
   assign PORT1_EMPH = p1_emph_r;
   assign PORT2_EMPH = p2_emph_r;
   assign PORT1_SLEW = p1_slew_r;
   assign PORT2_SLEW = p2_slew_r;
   assign PORT1_SRC_TERM = p1_term_r;
   assign PORT2_SRC_TERM = p2_term_r;
   assign PORT1_CLK_SWAP = clk_swap_r;
   assign PORT2_CLK_SWAP = clk_swap_r;
   assign RX_POWER = rx_pwr_r;
   assign DRV_POWER = drv_pwr_r;
   assign INPUT_TERMINATION_ON = term_on_r;
   assign INPUT_TERMINATION_TIED = term_tied_r;
   assign INPUT_TERMINATION_VDD = term_vdd_r;
   assign INPUT_PULLDOWN_ON = pd_on_r;
   assign SQUELCH = squelch_r;
   assign PORT_STATUS = port_status_r;

endmodule // tsc_strap_ctrl

/* File: dv/tsc_strap_ctrl_assertions.sv */
/*
 * port-level assertions for the strap and port control block.
 * assumes sync active-high reset and outputs registered one edge after inputs.
 */
`timescale 1ns/1ps
module tsc_strap_ctrl_chk
   import tsc_pkg::*;
(
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic CONTROL_MODE_STRAP,
   input wire logic SWING_STRAP_LOW,
   input wire logic SWING_STRAP_HIGH,
   input wire logic EMPHASIS_STRAP_LOW,
   input wire logic EMPHASIS_STRAP_HIGH,
   input wire logic OUTPUT_ENABLE_PIN,
   input wire logic BROADCAST_SELECT_PIN,
   input wire logic PORT_CHOICE_PIN,
   input wire logic TERM_SELECT_PIN,
   input wire logic CLK_POLARITY_SWAPPED,
   input wire logic CLK_DETECT,
   input wire logic SERIAL_MODE,
   input wire logic [6:0] CFG_BUS_ADDR,
   input wire logic PORT1_ACTIVE,
   input wire logic PORT2_ACTIVE,
   input wire logic [1:0] PORT1_SWING,
   input wire logic [1:0] PORT2_SWING,
   input wire logic [2:0] PORT1_EMPH,
   input wire logic [2:0] PORT2_EMPH,
   input wire logic PORT1_SRC_TERM,
   input wire logic PORT2_SRC_TERM,
   input wire logic PORT1_CLK_SWAP,
   input wire logic PORT2_CLK_SWAP,
   input wire logic RX_POWER,
   input wire logic DRV_POWER,
   input wire logic INPUT_TERMINATION_ON,
   input wire logic INPUT_TERMINATION_TIED,
   input wire logic INPUT_PULLDOWN_ON,
   input wire logic SQUELCH
);
   // one clock domain, reset masks every check
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);

   // strap to output relations one edge apart, then a same-cycle pull-down check
   property p_mode; !SYS_RST |=> SERIAL_MODE == $past(CONTROL_MODE_STRAP); endproperty
   a_mode: assert property (p_mode) else $error("mode output wrong");
   property p_addr; !SYS_RST |=> CFG_BUS_ADDR == {3'h5, $past(EMPHASIS_STRAP_HIGH), $past(EMPHASIS_STRAP_LOW),
      $past(SWING_STRAP_HIGH), $past(SWING_STRAP_LOW)}; endproperty
   a_addr: assert property (p_addr) else $error("bus address wrong");
   property p_swap; !SYS_RST |=> {PORT1_CLK_SWAP, PORT2_CLK_SWAP} == {2{$past(CLK_POLARITY_SWAPPED)}}; endproperty
   a_swap: assert property (p_swap) else $error("clock swap wrong");
   property p_swing; !SYS_RST && !CONTROL_MODE_STRAP
      |=> PORT1_SWING == {$past(SWING_STRAP_HIGH), $past(SWING_STRAP_LOW)} && PORT2_SWING == PORT1_SWING;
   endproperty
   a_swing: assert property (p_swing) else $error("swing wrong");
   property p_emph; !SYS_RST && !CONTROL_MODE_STRAP |=> PORT1_EMPH == {1'b0, $past(EMPHASIS_STRAP_HIGH),
      $past(EMPHASIS_STRAP_LOW)} && PORT2_EMPH == PORT1_EMPH; endproperty
   a_emph: assert property (p_emph) else $error("emphasis wrong");
   property p_term; !SYS_RST && !CONTROL_MODE_STRAP
      |=> {PORT1_SRC_TERM, PORT2_SRC_TERM} == {2{$past(TERM_SELECT_PIN)}};
   endproperty
   a_term: assert property (p_term) else $error("termination wrong");
   property p_off; !OUTPUT_ENABLE_PIN |=> !(PORT1_ACTIVE | PORT2_ACTIVE | RX_POWER | DRV_POWER
      | INPUT_TERMINATION_ON); endproperty
   a_off: assert property (p_off) else $error("disable incomplete");
   property p_bcast; !SYS_RST && OUTPUT_ENABLE_PIN && !CONTROL_MODE_STRAP && BROADCAST_SELECT_PIN && CLK_DETECT
      |=> PORT1_ACTIVE && PORT2_ACTIVE; endproperty
   a_bcast: assert property (p_bcast) else $error("broadcast wrong");
   property p_single; !SYS_RST && OUTPUT_ENABLE_PIN && !CONTROL_MODE_STRAP && !BROADCAST_SELECT_PIN && CLK_DETECT
      |=> PORT2_ACTIVE == $past(PORT_CHOICE_PIN) && PORT1_ACTIVE != $past(PORT_CHOICE_PIN); endproperty
   a_single: assert property (p_single) else $error("single port wrong");
   property p_sq; !SYS_RST && OUTPUT_ENABLE_PIN && !CONTROL_MODE_STRAP && !CLK_DETECT
      |=> SQUELCH && !PORT1_ACTIVE && !PORT2_ACTIVE; endproperty
   a_sq: assert property (p_sq) else $error("squelch wrong");
   property p_pull; INPUT_TERMINATION_TIED |-> !INPUT_PULLDOWN_ON; endproperty
   a_pull: assert property (p_pull) else $error("pulldown on while tied");
endmodule // tsc_strap_ctrl_chk

bind tsc_strap_ctrl tsc_strap_ctrl_chk u_chk (.CLOCK, .SYS_RST, .CONTROL_MODE_STRAP, .SWING_STRAP_LOW,
   .SWING_STRAP_HIGH, .EMPHASIS_STRAP_LOW, .EMPHASIS_STRAP_HIGH, .OUTPUT_ENABLE_PIN, .BROADCAST_SELECT_PIN,
   .PORT_CHOICE_PIN, .TERM_SELECT_PIN, .CLK_POLARITY_SWAPPED, .CLK_DETECT, .SERIAL_MODE, .CFG_BUS_ADDR,
   .PORT1_ACTIVE, .PORT2_ACTIVE, .PORT1_SWING, .PORT2_SWING, .PORT1_EMPH, .PORT2_EMPH, .PORT1_SRC_TERM,
   .PORT2_SRC_TERM, .PORT1_CLK_SWAP, .PORT2_CLK_SWAP, .RX_POWER, .DRV_POWER, .INPUT_TERMINATION_ON,
   .INPUT_TERMINATION_TIED, .INPUT_PULLDOWN_ON, .SQUELCH);

/* File: dv/tsc_src_model.sv */
/*
 * video source model: clock detector level and clock pair orientation.
 * assumes the bench commands both levels on CLOCK.
 */
`timescale 1ns/1ps
module tsc_src_model (
   input wire logic CLOCK,
   input wire logic clk_on,
   input wire logic swap_in,
   output logic CLK_DETECT = 1'b1,
   output logic CLK_POLARITY_SWAPPED = 1'b0
);
   // levels move just after an edge
   always @(posedge CLOCK) begin
      CLK_DETECT <= clk_on;
      CLK_POLARITY_SWAPPED <= swap_in;
   end
endmodule // tsc_src_model

/* File: dv/tb_top.sv */
/*
 * self-checking bench: wishbone registers, strap decode, serial overrides.
 * assumes the source model beside the block and a 10 MHz clock.
 */
`timescale 1ns/1ps
module tb_top;
   import tsc_pkg::*;
   logic CLOCK = 0, SYS_RST = 1, WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0, WB_ACK_O, probe = 0;
   logic [7:0] WB_ADR_I = 0;
   logic [3:0] WB_SEL_I = 0;
   logic [31:0] WB_DAT_I = 0, WB_DAT_O, seed = 32'hd97e;
   logic CONTROL_MODE_STRAP = 0, EQUALIZER_STRAP_HIGH = 0, EQUALIZER_STRAP_HIGH_FLOAT = 1;
   logic EQUALIZER_STRAP_LOW = 0, EQUALIZER_STRAP_LOW_FLOAT = 1, SWING_STRAP_LOW = 0, SWING_STRAP_HIGH = 0;
   logic EMPHASIS_STRAP_LOW = 0, EMPHASIS_STRAP_HIGH = 0, OUTPUT_ENABLE_PIN = 1, BROADCAST_SELECT_PIN = 1;
   logic PORT_CHOICE_PIN = 0, TERM_SELECT_PIN = 1, CLK_POLARITY_SWAPPED, CLK_DETECT, clk_on = 1, swap_in = 0;
   logic SERIAL_MODE, PORT1_ACTIVE, PORT2_ACTIVE, PORT1_SRC_TERM, PORT2_SRC_TERM, PORT1_CLK_SWAP;
   logic PORT2_CLK_SWAP, RX_POWER, DRV_POWER, INPUT_TERMINATION_ON, INPUT_TERMINATION_TIED;
   logic INPUT_TERMINATION_VDD, INPUT_PULLDOWN_ON, SQUELCH, PORT_STATUS;
   logic [6:0] CFG_BUS_ADDR;
   logic [2:0] EQ_STEP, PORT1_EMPH, PORT2_EMPH;
   logic [1:0] PORT1_SWING, PORT2_SWING, PORT1_SLEW, PORT2_SLEW;
   logic [32:0] q[$];
   logic [7:0] rst_tab[7] = '{RST_CFG, RST_RX, RST_RSV2, RST_TX, RST_TX, RST_RSV5, RST_RSV6};
   int eq_hi[8] = '{0, 0, 1, 0, 1, 2, 2, 2};
   int eq_lo[8] = '{1, 0, 0, 2, 1, 0, 1, 2};
   int error_cnt = 0, checked = 0, cycles = 0;
   // port, power and termination outputs packed for one compare
   wire [31:0] pv = {5'h0, EQ_STEP, INPUT_TERMINATION_ON, INPUT_TERMINATION_TIED, INPUT_TERMINATION_VDD,
      INPUT_PULLDOWN_ON, RX_POWER, DRV_POWER, SQUELCH, PORT_STATUS, PORT1_SRC_TERM, PORT2_SRC_TERM,
      PORT1_EMPH, PORT2_EMPH, PORT1_SWING, PORT2_SWING, PORT1_SLEW, PORT2_SLEW};

   tsc_strap_ctrl uut (.CLOCK, .SYS_RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I,
      .WB_DAT_O, .WB_ACK_O, .CONTROL_MODE_STRAP, .EQUALIZER_STRAP_HIGH, .EQUALIZER_STRAP_HIGH_FLOAT,
      .EQUALIZER_STRAP_LOW, .EQUALIZER_STRAP_LOW_FLOAT, .SWING_STRAP_LOW, .SWING_STRAP_HIGH,
      .EMPHASIS_STRAP_LOW, .EMPHASIS_STRAP_HIGH, .OUTPUT_ENABLE_PIN, .BROADCAST_SELECT_PIN, .PORT_CHOICE_PIN,
      .TERM_SELECT_PIN, .CLK_POLARITY_SWAPPED, .CLK_DETECT, .SERIAL_MODE, .CFG_BUS_ADDR, .EQ_STEP,
      .PORT1_ACTIVE, .PORT2_ACTIVE, .PORT1_SWING, .PORT2_SWING, .PORT1_EMPH, .PORT2_EMPH, .PORT1_SLEW,
      .PORT2_SLEW, .PORT1_SRC_TERM, .PORT2_SRC_TERM, .PORT1_CLK_SWAP, .PORT2_CLK_SWAP, .RX_POWER, .DRV_POWER,
      .INPUT_TERMINATION_ON, .INPUT_TERMINATION_TIED, .INPUT_TERMINATION_VDD, .INPUT_PULLDOWN_ON, .SQUELCH,
      .PORT_STATUS);
   tsc_src_model src (.CLOCK, .clk_on, .swap_in, .CLK_DETECT, .CLK_POLARITY_SWAPPED);

   // clock
   always #50 CLOCK = ~CLOCK;

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [31:0] sv(logic ser, logic sq, logic p1, logic p2, logic [2:0] eq);
      return {24'h0, 1'b0, eq, p2, p1, sq, ser};
   endfunction

   task automatic conclude();
      if (error_cnt == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // classic single wishbone cycle, held until ack
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLOCK);
      WB_CYC_I <= 1;
      WB_STB_I <= 1;
      WB_WE_I <= we;
      WB_ADR_I <= a;
      WB_SEL_I <= 4'h1;
      WB_DAT_I <= d;
      do @(posedge CLOCK); while (WB_ACK_O !== 1'b1);
      WB_CYC_I <= 0;
      WB_STB_I <= 0;
      WB_WE_I <= 0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      q.push_back({1'b0, e});
      wb(0, a, 32'h0);
   endtask

   task automatic pr(input logic [31:0] e);
      q.push_back({1'b1, e});
      @(posedge CLOCK);
      probe <= 1;
      @(posedge CLOCK);
      probe <= 0;
   endtask

   // compare each result with the oldest note
   always @(posedge CLOCK) begin
      logic [32:0] e;
      if ((WB_ACK_O === 1'b1 && !WB_WE_I) || probe) begin
         e = q.pop_front();
         checked++;
         if (e[31:0] !== (e[32] ? pv : WB_DAT_O)) begin
            error_cnt++;
            $display("ERROR %s exp %h got %h", e[32] ? "ports" : "rdata", e[31:0], e[32] ? pv : WB_DAT_O);
         end
      end
   end

   // hang guard
   always @(posedge CLOCK) begin
      cycles++;
      if (cycles == 5000) begin
         error_cnt++;
         $display("ERROR timeout exp %0d got %0d", 5000, cycles);
         conclude();
      end
   end

   initial begin
      logic [31:0] r;
      logic p1, p2;
      repeat (5) @(posedge CLOCK);
      SYS_RST <= 0;
      for (int i = 0; i < 7; i++) rd(8'(i * 4), {24'h0, rst_tab[i]});
      wb(1, 8'h08, 32'ha5);
      rd(8'h08, 32'ha5);
      wb(1, 8'h20, 32'h5a);
      rd(8'h20, 32'h0);
      rd(8'h01, 32'h0);
      wb(1, 8'h1c, 32'hff);
      // random pin straps
      for (int i = 0; i < 12; i++) begin
         r = xs();
         {SWING_STRAP_HIGH, SWING_STRAP_LOW} <= r[1:0];
         {EMPHASIS_STRAP_HIGH, EMPHASIS_STRAP_LOW} <= r[3:2];
         BROADCAST_SELECT_PIN <= r[4];
         PORT_CHOICE_PIN <= r[5];
         TERM_SELECT_PIN <= r[6];
         repeat (3) @(posedge CLOCK);
         p1 = r[4] | !r[5];
         p2 = r[4] | r[5];
         pr({5'h0, 3'h4, 7'h4e, 1'b1, r[6], r[6], 1'b0, r[3:2], 1'b0, r[3:2], r[1:0], r[1:0], 4'h0});
         rd(8'h1c, sv(0, 0, p1, p2, 3'h4));
      end
      // three-level equalizer table
      for (int i = 0; i < 8; i++) begin
         EQUALIZER_STRAP_HIGH <= eq_hi[i] == 2;
         EQUALIZER_STRAP_HIGH_FLOAT <= eq_hi[i] == 1;
         EQUALIZER_STRAP_LOW <= eq_lo[i] == 2;
         EQUALIZER_STRAP_LOW_FLOAT <= eq_lo[i] == 1;
         repeat (3) @(posedge CLOCK);
         rd(8'h1c, sv(0, 0, p1, p2, 3'(i)));
      end
      clk_on <= 0;
      swap_in <= 1;
      repeat (3) @(posedge CLOCK);
      rd(8'h1c, sv(0, 1, 0, 0, 3'h7));
      OUTPUT_ENABLE_PIN <= 0;
      repeat (3) @(posedge CLOCK);
      rd(8'h1c, sv(0, 0, 0, 0, 3'h7));
      OUTPUT_ENABLE_PIN <= 1;
      CONTROL_MODE_STRAP <= 1;
      wb(1, 8'h0c, 32'hb9);
      wb(1, 8'h10, 32'h56);
      wb(1, 8'h04, 32'h6e);
      wb(1, 8'h00, 32'hdf);
      repeat (3) @(posedge CLOCK);
      pr({5'h0, 3'h3, 7'h76, 1'b0, 1'b1, 1'b0, 3'h3, 3'h5, 2'h2, 2'h1, 2'h1, 2'h2});
      rd(8'h1c, sv(1, 0, 0, 1, 3'h3));
      wb(1, 8'h00, 32'h5f);
      repeat (3) @(posedge CLOCK);
      rd(8'h1c, sv(1, 0, 0, 0, 3'h3));
      // let the last compare run before the verdict
      repeat (2) @(posedge CLOCK);
      if (q.size() != 0) begin
         error_cnt++;
         $display("ERROR queue exp %0d got %0d", 0, q.size());
      end
      conclude();
   end
endmodule // tb_top
